// ==== rtl/dofs_top.sv ====
// drive output function selector: routes status conditions to terminals
`timescale 1ns/1ps
`include "dofs_consts.svh"
module dofs_top #(
  parameter int ZP_CYCLES = `DOFS_ZP_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`DOFS_CODE_W-1:0] sel_relay_one,
  input wire logic [`DOFS_CODE_W-1:0] sel_relay_two,
  input wire logic [`DOFS_CODE_W-1:0] sel_oc,
  input wire logic [`DOFS_CODE_W-1:0] sel_fast,
  input wire dofs_pkg::dofs_fp_mode_e fast_mode,
  input wire logic pulse_train_in,
  input wire logic run_active,
  input wire logic dir_reverse,
  input wire logic jog_active,
  input wire logic out_freq_zero,
  input wire logic ref_freq_zero,
  input wire logic drive_fault,
  input wire logic freq_level_detect_one,
  input wire logic freq_level_detect_two,
  input wire logic freq_reached,
  input wire logic at_upper_limit,
  input wire logic at_lower_limit,
  input wire logic main_power_ok,
  input wire logic ctrl_power_ok,
  input wire logic protect_active,
  input wire logic ready_to_run,
  input wire logic pre_excite,
  input wire logic overload_prealarm,
  input wire logic underload_prealarm,
  input wire logic step_sequencer_stage_done,
  input wire logic step_sequencer_cycle_done,
  input wire logic [`DOFS_NUM_TERM-1:0] vbit_modbus,
  input wire logic [`DOFS_NUM_TERM-1:0] vbit_fieldbus,
  input wire logic [`DOFS_NUM_TERM-1:0] vbit_ether,
  input wire logic [`DOFS_NUM_TERM-1:0] vbit_ind_ether,
  input wire logic dc_bus_above_uv,
  input wire logic enc_index_pulse,
  input wire logic pulse_superpose,
  input wire logic safe_torque_off_fault,
  input wire logic position_done,
  input wire logic spindle_zero_done,
  input wire logic spindle_div_done,
  input wire logic freq_limiting,
  input wire logic mode_switch_done,
  input wire logic [`DOFS_FREQ_W-1:0] ramp_freq,
  input wire logic [`DOFS_FREQ_W-1:0] reach_detect,
  output logic relay_one_out,
  output logic relay_two_out,
  output logic oc_out,
  output logic fast_pulse_out_pin
);

  // ****************************************
  // declarations
  // ****************************************
  dofs_pkg::dofs_top_s st_q;
  dofs_pkg::dofs_top_s st_d;
  logic [`DOFS_NUM_CODES-1:0] cond_common;
  logic [`DOFS_NUM_TERM-1:0][`DOFS_CODE_W-1:0] sel_all;
  logic [`DOFS_NUM_TERM-1:0] term_level;
  // unpacked, so each generate branch owns a whole element of its own
  logic [`DOFS_NUM_CODES-1:0] cond_term [`DOFS_NUM_TERM];
  logic freq_out;
  dofs_zp_if zp_link ();

  // picks one condition by code; codes with no source read as zero
  function automatic logic dofs_pick(
    input logic [`DOFS_NUM_CODES-1:0] cond,
    input logic [`DOFS_CODE_W-1:0] code
  );
    dofs_pick = cond[code];
  endfunction

  // ****************************************
  // index pulse stretcher
  // ****************************************
  assign zp_link.trig = enc_index_pulse;

  dofs_zp_stretch #(
    .ZP_CYCLES(ZP_CYCLES)
  ) u_zp (
    .clk(clk),
    .reset(reset),
    .zp(zp_link)
  );

  // ****************************************
  // condition vector shared by all terminals
  // ****************************************
  // frequency output is taken as the inverse of the zero-frequency flag
  assign freq_out = ~out_freq_zero;

  // unassigned entries stay zero, which covers code 0 and reserved codes
  always_comb begin
    cond_common = '0;
    cond_common[`DOFS_SEL_RUN] = run_active & freq_out;
    cond_common[`DOFS_SEL_FWD] = run_active & freq_out & ~dir_reverse;
    cond_common[`DOFS_SEL_REV] = run_active & freq_out & dir_reverse;
    cond_common[`DOFS_SEL_JOG] = jog_active & freq_out;
    cond_common[`DOFS_SEL_FAULT] = drive_fault;
    cond_common[`DOFS_SEL_FDT_ONE] = freq_level_detect_one;
    cond_common[`DOFS_SEL_FDT_TWO] = freq_level_detect_two;
    cond_common[`DOFS_SEL_REACHED] = freq_reached;
    cond_common[`DOFS_SEL_ZERO_SPD] = out_freq_zero & ref_freq_zero;
    cond_common[`DOFS_SEL_UPPER] = at_upper_limit;
    cond_common[`DOFS_SEL_LOWER] = at_lower_limit;
    cond_common[`DOFS_SEL_READY] = main_power_ok & ctrl_power_ok
                                 & ~protect_active & ready_to_run;
    cond_common[`DOFS_SEL_PREEXC] = pre_excite;
    // the pre-alarm timing is done where the load is measured
    cond_common[`DOFS_SEL_OVL] = overload_prealarm;
    cond_common[`DOFS_SEL_UNL] = underload_prealarm;
    cond_common[`DOFS_SEL_STAGE] = step_sequencer_stage_done;
    cond_common[`DOFS_SEL_CYCLE] = step_sequencer_cycle_done;
    cond_common[`DOFS_SEL_DC_BUS] = dc_bus_above_uv;
    cond_common[`DOFS_SEL_INDEX] = zp_link.hold;
    cond_common[`DOFS_SEL_SUPERPOS] = pulse_superpose;
    cond_common[`DOFS_SEL_STO] = safe_torque_off_fault;
    cond_common[`DOFS_SEL_POS_DONE] = position_done;
    cond_common[`DOFS_SEL_SP_ZERO] = spindle_zero_done;
    cond_common[`DOFS_SEL_SP_DIV] = spindle_div_done;
    cond_common[`DOFS_SEL_LIMITING] = freq_limiting;
    cond_common[`DOFS_SEL_MODE_SW] = mode_switch_done;
    cond_common[`DOFS_SEL_ANY_FREQ] = (ramp_freq > reach_detect);
  end

  // ****************************************
  // per-terminal selection
  // ****************************************
  assign sel_all[`DOFS_TERM_RELAY_ONE] = sel_relay_one;
  assign sel_all[`DOFS_TERM_RELAY_TWO] = sel_relay_two;
  assign sel_all[`DOFS_TERM_OC] = sel_oc;
  assign sel_all[`DOFS_TERM_FAST] = sel_fast;

  // virtual bits are per terminal, so each terminal gets its own vector
  generate
    for (genvar t = 0; t < `DOFS_NUM_TERM; t++) begin : g_term
      always_comb begin
        cond_term[t] = cond_common;
        cond_term[t][`DOFS_SEL_VB_MODBUS] = vbit_modbus[t];
        cond_term[t][`DOFS_SEL_VB_FBUS] = vbit_fieldbus[t];
        cond_term[t][`DOFS_SEL_VB_ETH] = vbit_ether[t];
        cond_term[t][`DOFS_SEL_VB_INDETH] = vbit_ind_ether[t];
      end
      assign term_level[t] = dofs_pick(cond_term[t], sel_all[t]);
    end
  endgenerate

  // ****************************************
  // output registers
  // ****************************************
  // in pulse mode the fast pin carries the generator train, one cycle late
  always_comb begin
    st_d = st_q;
    st_d.term = term_level;
    if (fast_mode == dofs_pkg::DOFS_FP_PULSE) begin
      st_d.term[`DOFS_TERM_FAST] = pulse_train_in;
    end
  end

  // every output leaves from a flop, so field wiring sees no glitches
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign relay_one_out = st_q.term[`DOFS_TERM_RELAY_ONE];
  assign relay_two_out = st_q.term[`DOFS_TERM_RELAY_TWO];
  assign oc_out = st_q.term[`DOFS_TERM_OC];
  assign fast_pulse_out_pin = st_q.term[`DOFS_TERM_FAST];

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // virtual bits are per terminal, so a shared bus code only agrees when the bits do
  shared_code_a: assert property (
    (sel_relay_one == sel_oc
      && vbit_modbus[`DOFS_TERM_RELAY_ONE] == vbit_modbus[`DOFS_TERM_OC]
      && vbit_fieldbus[`DOFS_TERM_RELAY_ONE] == vbit_fieldbus[`DOFS_TERM_OC]
      && vbit_ether[`DOFS_TERM_RELAY_ONE] == vbit_ether[`DOFS_TERM_OC]
      && vbit_ind_ether[`DOFS_TERM_RELAY_ONE] == vbit_ind_ether[`DOFS_TERM_OC])
      |=> (relay_one_out == oc_out))
    else $error("terminals with one code disagree");

  fast_pulse_a: assert property (
    (fast_mode == dofs_pkg::DOFS_FP_PULSE) |=>
      (fast_pulse_out_pin == $past(pulse_train_in)))
    else $error("fast pin does not follow pulse train");

  fast_digital_a: assert property (
    (fast_mode == dofs_pkg::DOFS_FP_DIGITAL && sel_fast == `DOFS_SEL_FAULT) |=>
      (fast_pulse_out_pin == $past(drive_fault)))
    else $error("fast pin as digital output wrong");

  code_zero_a: assert property (
    (sel_relay_one == `DOFS_SEL_NONE) |=> !relay_one_out)
    else $error("code zero terminal not inactive");

  run_out_a: assert property (
    (sel_relay_two == `DOFS_SEL_RUN) |=>
      (relay_two_out == ($past(run_active) && !$past(out_freq_zero))))
    else $error("running output wrong");

  reverse_out_a: assert property (
    (sel_oc == `DOFS_SEL_REV && run_active && !out_freq_zero) |=>
      (oc_out == $past(dir_reverse)))
    else $error("reverse running output wrong");

  fault_out_a: assert property (
    (sel_relay_one == `DOFS_SEL_FAULT) |=>
      (relay_one_out == $past(drive_fault)))
    else $error("fault output wrong");

  zero_speed_a: assert property (
    (sel_relay_two == `DOFS_SEL_ZERO_SPD && out_freq_zero && !ref_freq_zero)
      |=> !relay_two_out)
    else $error("zero speed on with reference set");

  ready_out_a: assert property (
    (sel_oc == `DOFS_SEL_READY && protect_active) |=> !oc_out)
    else $error("ready shown while protection active");

  vbit_mirror_a: assert property (
    (sel_relay_one == `DOFS_SEL_VB_MODBUS) |=>
      (relay_one_out == $past(vbit_modbus[`DOFS_TERM_RELAY_ONE])))
    else $error("virtual bit not mirrored");

  ind_eth_a: assert property (
    (sel_oc == `DOFS_SEL_VB_INDETH) |=>
      (oc_out == $past(vbit_ind_ether[`DOFS_TERM_OC])))
    else $error("industrial fieldbus bit not mirrored");

  index_hold_a: assert property (
    (sel_oc == `DOFS_SEL_INDEX && enc_index_pulse && !u_zp.st_q.prev)
      ##1 (sel_oc == `DOFS_SEL_INDEX) |=> oc_out)
    else $error("index pulse not shown");

  ramp_cmp_a: assert property (
    (sel_oc == `DOFS_SEL_ANY_FREQ) |=>
      (oc_out == ($past(ramp_freq) > $past(reach_detect))))
    else $error("ramp compare output wrong");

  reserved_a: assert property (
    (sel_relay_one == `DOFS_SEL_RSVD) |=> !relay_one_out)
    else $error("reserved code drove terminal");

  // the plain routed flags other than spindle_zero_done, spindle_div_done and mode_switch_done are spread over the terminals so that each path is watched
  forward_out_a: assert property (
    (sel_relay_one == `DOFS_SEL_FWD) |=>
      (relay_one_out == ($past(run_active) && !$past(dir_reverse) && !$past(out_freq_zero))))
    else $error("forward running output wrong");

  jog_out_a: assert property (
    (sel_relay_two == `DOFS_SEL_JOG) |=>
      (relay_two_out == ($past(jog_active) && !$past(out_freq_zero))))
    else $error("jogging output wrong");

  level_one_a: assert property (
    (sel_oc == `DOFS_SEL_FDT_ONE) |=> (oc_out == $past(freq_level_detect_one)))
    else $error("first level detect not routed");

  level_two_a: assert property (
    (sel_relay_one == `DOFS_SEL_FDT_TWO) |=>
      (relay_one_out == $past(freq_level_detect_two)))
    else $error("second level detect not routed");

  freq_reach_a: assert property (
    (sel_relay_two == `DOFS_SEL_REACHED) |=> (relay_two_out == $past(freq_reached)))
    else $error("frequency reached not routed");

  upper_limit_a: assert property (
    (sel_oc == `DOFS_SEL_UPPER) |=> (oc_out == $past(at_upper_limit)))
    else $error("upper limit not routed");

  lower_limit_a: assert property (
    (sel_relay_one == `DOFS_SEL_LOWER) |=> (relay_one_out == $past(at_lower_limit)))
    else $error("lower limit not routed");

  pre_excite_a: assert property (
    (sel_relay_two == `DOFS_SEL_PREEXC) |=> (relay_two_out == $past(pre_excite)))
    else $error("pre-excitation not routed");

  overload_out_a: assert property (
    (sel_oc == `DOFS_SEL_OVL) |=> (oc_out == $past(overload_prealarm)))
    else $error("overload pre-alarm not routed");

  underload_out_a: assert property (
    (sel_relay_one == `DOFS_SEL_UNL) |=>
      (relay_one_out == $past(underload_prealarm)))
    else $error("underload pre-alarm not routed");

  stage_done_a: assert property (
    (sel_relay_two == `DOFS_SEL_STAGE) |=>
      (relay_two_out == $past(step_sequencer_stage_done)))
    else $error("sequencer stage not routed");

  cycle_done_a: assert property (
    (sel_oc == `DOFS_SEL_CYCLE) |=> (oc_out == $past(step_sequencer_cycle_done)))
    else $error("sequencer cycle not routed");

  fieldbus_bit_a: assert property (
    (sel_relay_two == `DOFS_SEL_VB_FBUS) |=>
      (relay_two_out == $past(vbit_fieldbus[`DOFS_TERM_RELAY_TWO])))
    else $error("fieldbus bit not mirrored");

  ether_bit_a: assert property (
    (fast_mode == dofs_pkg::DOFS_FP_DIGITAL && sel_fast == `DOFS_SEL_VB_ETH) |=>
      (fast_pulse_out_pin == $past(vbit_ether[`DOFS_TERM_FAST])))
    else $error("network bit not mirrored");

  dc_bus_a: assert property (
    (sel_relay_one == `DOFS_SEL_DC_BUS) |=> (relay_one_out == $past(dc_bus_above_uv)))
    else $error("dc bus state not routed");

  superpose_out_a: assert property (
    (sel_oc == `DOFS_SEL_SUPERPOS) |=> (oc_out == $past(pulse_superpose)))
    else $error("superposition not routed");

  torque_off_a: assert property (
    (sel_relay_two == `DOFS_SEL_STO) |=>
      (relay_two_out == $past(safe_torque_off_fault)))
    else $error("torque off fault not routed");

  position_out_a: assert property (
    (sel_oc == `DOFS_SEL_POS_DONE) |=> (oc_out == $past(position_done)))
    else $error("positioning done not routed");

  limiting_out_a: assert property (
    (sel_relay_one == `DOFS_SEL_LIMITING) |=> (relay_one_out == $past(freq_limiting)))
    else $error("frequency limiting not routed");

  // main scenarios
  cover_shared: cover property (
    (sel_relay_one == sel_relay_two && sel_relay_one != `DOFS_SEL_NONE)
      ##1 relay_one_out);
  cover_index: cover property (
    (sel_oc == `DOFS_SEL_INDEX) ##1 $rose(oc_out));
  cover_fast_dig: cover property (
    (fast_mode == dofs_pkg::DOFS_FP_DIGITAL) ##1 $rose(fast_pulse_out_pin));
  cover_vbit: cover property (
    (sel_relay_two == `DOFS_SEL_VB_ETH) ##1 $fell(relay_two_out));

endmodule

// ==== rtl/dofs_consts.svh ====
// constants for the drive output function selector
`ifndef DOFS_CONSTS_SVH
`define DOFS_CONSTS_SVH

// ****************************************
// geometry
// ****************************************
`define DOFS_CODE_W 6
`define DOFS_NUM_TERM 4
`define DOFS_NUM_CODES 64
`define DOFS_FREQ_W 16
`define DOFS_TERM_RELAY_ONE 0
`define DOFS_TERM_RELAY_TWO 1
`define DOFS_TERM_OC 2
`define DOFS_TERM_FAST 3

// ****************************************
// selection codes
// ****************************************
`define DOFS_SEL_NONE 6'h00
`define DOFS_SEL_RUN 6'h01
`define DOFS_SEL_FWD 6'h02
`define DOFS_SEL_REV 6'h03
`define DOFS_SEL_JOG 6'h04
`define DOFS_SEL_FAULT 6'h05
`define DOFS_SEL_FDT_ONE 6'h06
`define DOFS_SEL_FDT_TWO 6'h07
`define DOFS_SEL_REACHED 6'h08
`define DOFS_SEL_ZERO_SPD 6'h09
`define DOFS_SEL_UPPER 6'h0a
`define DOFS_SEL_LOWER 6'h0b
`define DOFS_SEL_READY 6'h0c
`define DOFS_SEL_PREEXC 6'h0d
`define DOFS_SEL_OVL 6'h0e
`define DOFS_SEL_UNL 6'h0f
`define DOFS_SEL_STAGE 6'h10
`define DOFS_SEL_CYCLE 6'h11
`define DOFS_SEL_VB_MODBUS 6'h17
`define DOFS_SEL_VB_FBUS 6'h18
`define DOFS_SEL_VB_ETH 6'h19
`define DOFS_SEL_DC_BUS 6'h1a
`define DOFS_SEL_INDEX 6'h1b
`define DOFS_SEL_SUPERPOS 6'h1c
`define DOFS_SEL_STO 6'h1d
`define DOFS_SEL_POS_DONE 6'h1e
`define DOFS_SEL_SP_ZERO 6'h1f
`define DOFS_SEL_SP_DIV 6'h20
`define DOFS_SEL_LIMITING 6'h21
`define DOFS_SEL_VB_INDETH 6'h22
`define DOFS_SEL_RSVD 6'h23
`define DOFS_SEL_MODE_SW 6'h24
`define DOFS_SEL_ANY_FREQ 6'h25

// ****************************************
// timing
// ****************************************
`define DOFS_CLK_HZ 25000000
`define DOFS_ZP_TIME_MS 10
`define DOFS_ZP_CYCLES ((`DOFS_ZP_TIME_MS * `DOFS_CLK_HZ) / 1000)
`define DOFS_ZP_CNT_W 18

`endif

// ==== rtl/dofs_pkg.sv ====
// types shared by the drive output function selector
`include "dofs_consts.svh"
package dofs_pkg;

  // how the fast pulse pin is used
  typedef enum logic {
    DOFS_FP_PULSE = 1'b0,
    DOFS_FP_DIGITAL = 1'b1
  } dofs_fp_mode_e;

  // registered terminal levels of the top
  typedef struct packed {
    logic [`DOFS_NUM_TERM-1:0] term;
  } dofs_top_s;

  // index pulse stretcher state
  typedef struct packed {
    logic prev;
    logic [`DOFS_ZP_CNT_W-1:0] cnt;
  } dofs_zp_s;

endpackage

// ==== rtl/dofs_zp_if.sv ====
// link between the selector and its index pulse stretcher
`timescale 1ns/1ps
interface dofs_zp_if;
  logic trig;
  logic hold;
  modport src (output trig, input hold);
  modport stretch (input trig, output hold);
endinterface

// ==== rtl/dofs_zp_stretch.sv ====
// stretches an encoder index pulse into a fixed-length level
`timescale 1ns/1ps
`include "dofs_consts.svh"
module dofs_zp_stretch #(
  parameter int ZP_CYCLES = `DOFS_ZP_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  dofs_zp_if.stretch zp
);

  dofs_pkg::dofs_zp_s st_q;
  dofs_pkg::dofs_zp_s st_d;
  logic edge_seen;

  // a new index edge restarts the window, so close pulses merge
  always_comb begin
    st_d = st_q;
    edge_seen = zp.trig & ~st_q.prev;
    st_d.prev = zp.trig;
    if (edge_seen) begin
      st_d.cnt = ZP_CYCLES[`DOFS_ZP_CNT_W-1:0];
    end else if (st_q.cnt != '0) begin
      st_d.cnt = st_q.cnt - `DOFS_ZP_CNT_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign zp.hold = (st_q.cnt != '0);

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  index_start_a: assert property (
    (zp.trig && !st_q.prev) |=> zp.hold)
    else $error("index edge did not start hold");
  index_count_a: assert property (
    (zp.trig && !st_q.prev) |=> (st_q.cnt == ZP_CYCLES[`DOFS_ZP_CNT_W-1:0]))
    else $error("index hold length wrong");

endmodule

// ==== tb/dofs_field_model.sv ====
// field wiring model that sits on the four output terminals
`timescale 1ns/1ps
module dofs_field_model (
  input wire logic relay_one_out,
  input wire logic relay_two_out,
  input wire logic oc_out,
  input wire logic fast_pulse_out_pin,
  output logic [3:0] seen
);
  // coils and loads follow the terminal level; no delay is modelled, so
  // the bench sees each level in the same cycle that the selector shows it
  assign seen = {fast_pulse_out_pin, oc_out, relay_two_out, relay_one_out};
endmodule

// ==== tb/dofs_top_tb.sv ====
// self-checking bench for the drive output function selector
`timescale 1ns/1ps
module dofs_top_tb;
  // ****************************************
  // stimulus and observation
  // ****************************************
  localparam int ZP = 8;
  logic clk, reset, pulse_train_in, enc_index_pulse;
  logic [5:0] sel_relay_one, sel_relay_two, sel_oc, sel_fast;
  dofs_pkg::dofs_fp_mode_e fast_mode;
  logic run_active, dir_reverse, jog_active, out_freq_zero, ref_freq_zero, drive_fault;
  logic freq_level_detect_one, freq_level_detect_two, freq_reached, at_upper_limit;
  logic at_lower_limit, main_power_ok, ctrl_power_ok, protect_active, ready_to_run;
  logic pre_excite, overload_prealarm, underload_prealarm, step_sequencer_stage_done;
  logic step_sequencer_cycle_done, dc_bus_above_uv, pulse_superpose, safe_torque_off_fault;
  logic position_done, spindle_zero_done, spindle_div_done, freq_limiting, mode_switch_done;
  logic [3:0] vbit_modbus, vbit_fieldbus, vbit_ether, vbit_ind_ether, seen, e;
  logic [15:0] ramp_freq, reach_detect;
  logic relay_one_out, relay_two_out, oc_out, fast_pulse_out_pin;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  logic [31:0] pats [8] = '{32'h0000_0000, 32'hffff_ffff, 32'h5555_5555, 32'haaaa_aaaa,
                            32'h0000_0001, 32'hc3c3_3c3c, 32'h0f0f_d8f0, 32'h9696_6969};

  dofs_top #(.ZP_CYCLES(ZP)) uut (.clk, .reset, .sel_relay_one, .sel_relay_two, .sel_oc,
    .sel_fast, .fast_mode, .pulse_train_in, .run_active, .dir_reverse, .jog_active,
    .out_freq_zero, .ref_freq_zero, .drive_fault, .freq_level_detect_one,
    .freq_level_detect_two, .freq_reached, .at_upper_limit, .at_lower_limit,
    .main_power_ok, .ctrl_power_ok, .protect_active, .ready_to_run, .pre_excite,
    .overload_prealarm, .underload_prealarm, .step_sequencer_stage_done,
    .step_sequencer_cycle_done, .vbit_modbus, .vbit_fieldbus, .vbit_ether, .vbit_ind_ether,
    .dc_bus_above_uv, .enc_index_pulse, .pulse_superpose, .safe_torque_off_fault,
    .position_done, .spindle_zero_done, .spindle_div_done, .freq_limiting,
    .mode_switch_done, .ramp_freq, .reach_detect, .relay_one_out, .relay_two_out, .oc_out,
    .fast_pulse_out_pin);

  dofs_field_model field (.relay_one_out, .relay_two_out, .oc_out, .fast_pulse_out_pin,
    .seen);

  // 25 MHz clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // hang guard: the whole run needs about 2100 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      end_sim();
    end
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // spreads one pattern over every status flag, vbit and frequency
  task automatic apply(input logic [31:0] p);
    logic [63:0] q;
    q = {p ^ 32'h3c5a_96e1, p};
    {run_active, dir_reverse, jog_active, out_freq_zero, ref_freq_zero, drive_fault,
     freq_level_detect_one, freq_level_detect_two, freq_reached, at_upper_limit,
     at_lower_limit, main_power_ok, ctrl_power_ok, protect_active, ready_to_run,
     pre_excite} = q[15:0];
    {overload_prealarm, underload_prealarm, step_sequencer_stage_done,
     step_sequencer_cycle_done, dc_bus_above_uv, pulse_superpose, safe_torque_off_fault,
     position_done, spindle_zero_done, spindle_div_done, freq_limiting,
     mode_switch_done, pulse_train_in} = q[28:16];
    {vbit_modbus, vbit_fieldbus, vbit_ether, vbit_ind_ether} = q[47:32];
    ramp_freq = p[15:0];
    reach_detect = p[31:16];
  endtask

  // expected level of terminal t for code c from the present inputs
  function automatic logic exp_term(input logic [5:0] c, input int t);
    logic fq;
    fq = !out_freq_zero;
    case (c)
      6'h01: return run_active & fq;
      6'h02: return run_active & !dir_reverse & fq;
      6'h03: return run_active & dir_reverse & fq;
      6'h04: return jog_active & fq;
      6'h05: return drive_fault;
      6'h06: return freq_level_detect_one;
      6'h07: return freq_level_detect_two;
      6'h08: return freq_reached;
      6'h09: return out_freq_zero & ref_freq_zero;
      6'h0a: return at_upper_limit;
      6'h0b: return at_lower_limit;
      6'h0c: return main_power_ok & ctrl_power_ok & !protect_active & ready_to_run;
      6'h0d: return pre_excite;
      6'h0e: return overload_prealarm;
      6'h0f: return underload_prealarm;
      6'h10: return step_sequencer_stage_done;
      6'h11: return step_sequencer_cycle_done;
      6'h17: return vbit_modbus[t];
      6'h18: return vbit_fieldbus[t];
      6'h19: return vbit_ether[t];
      6'h1a: return dc_bus_above_uv;
      6'h1c: return pulse_superpose;
      6'h1d: return safe_torque_off_fault;
      6'h1e: return position_done;
      6'h1f: return spindle_zero_done;
      6'h20: return spindle_div_done;
      6'h21: return freq_limiting;
      6'h22: return vbit_ind_ether[t];
      6'h24: return mode_switch_done;
      6'h25: return ramp_freq > reach_detect;
      default: return 1'b0;
    endcase
  endfunction

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    enc_index_pulse = 1'b0;
    fast_mode = dofs_pkg::DOFS_FP_DIGITAL;
    {sel_relay_one, sel_relay_two, sel_oc, sel_fast} = {4{6'h05}};
    apply(32'hffff_ffff);
    repeat (12) @(negedge clk);
    check(seen, 4'h0);
    reset = 1'b0;
    $display("test reset done");
    // index pulse is stretched into a fixed window on the open collector
    sel_oc = 6'h1b;
    repeat (3) @(negedge clk);
    enc_index_pulse = 1'b1;
    @(negedge clk);
    check({3'h0, oc_out}, 4'h0);
    repeat (ZP) begin
      @(negedge clk);
      check({3'h0, oc_out}, 4'h1);
    end
    @(negedge clk);
    check({3'h0, oc_out}, 4'h0);
    enc_index_pulse = 1'b0;
    $display("test index pulse done");
    // pulse mode passes the pulse train and ignores the code
    fast_mode = dofs_pkg::DOFS_FP_PULSE;
    sel_fast = 6'h05;
    for (int i = 0; i < 6; i++) begin
      pulse_train_in = i[0] ^ i[2];
      drive_fault = !pulse_train_in;
      @(negedge clk);
      check({3'h0, fast_pulse_out_pin}, {3'h0, pulse_train_in});
    end
    fast_mode = dofs_pkg::DOFS_FP_DIGITAL;
    $display("test pulse mode done");
    // every code on every terminal, shared and distinct, across patterns
    for (int k = 0; k < 8; k++) begin
      for (int c = 0; c < 64; c++) begin
        for (int s = 0; s < 2; s++) begin
          @(negedge clk);
          apply(pats[k]);
          sel_relay_one = c[5:0];
          sel_relay_two = s ? c[5:0] + 6'h07 : c[5:0];
          sel_oc = s ? c[5:0] + 6'h0d : c[5:0];
          sel_fast = s ? c[5:0] + 6'h1d : c[5:0];
          @(negedge clk);
          e = {exp_term(sel_fast, 3), exp_term(sel_oc, 2), exp_term(sel_relay_two, 1),
               exp_term(sel_relay_one, 0)};
          check(seen, e);
          check(seen, e);
        end
      end
    end
    $display("test code table done");
    end_sim();
  end
endmodule
